//--- lorl_chan.v
// One relay channel: OR of seven triggers, latching, hold and off-delay timing
`timescale 1ns/1ns
`default_nettype none
`include "lorl_regs.vh"
module lorl_chan (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    input wire tick,
    // Triggers and configuration
    input wire [`LORL_NTRIG-1:0] trig,
    input wire [`LORL_NTRIG-1:0] asg_en,
    input wire [`LORL_NTRIG-1:0] inv,
    input wire cinv,
    input wire mode,
    input wire latch_en,
    input wire ack,
    input wire [`LORL_TIME_W-1:0] hold_t,
    input wire [`LORL_TIME_W-1:0] off_t,
    // Retention
    input wire restore,
    input wire restore_val,
    // State
    output wire comb_st,
    output wire latch_q,
    output wire drive
);
    wire [`LORL_NTRIG-1:0] eff;
    wire any_asg;
    wire raw;
    wire off_done;
    wire clear_ok;
    wire state;
    wire want;
    reg latch_reg;
    reg drive_reg;
    reg [`LORL_TIME_W-1:0] off_reg;
    reg [`LORL_TIME_W-1:0] hold_reg;

    assign eff = asg_en & (trig ^ inv);
    assign any_asg = |asg_en;
    assign raw = |eff;
    assign comb_st = any_asg & (raw ^ cinv);
    assign off_done = ~raw && (off_reg == `LORL_RST_TIME);
    // Ack only counts once triggers dropped and the off-delay ran out
    assign clear_ok = off_done & (ack | ~latch_en | ~any_asg);
    assign state = latch_en ? (latch_reg | comb_st) : comb_st;
    assign want = state ^ mode;
    assign latch_q = latch_reg;
    assign drive = drive_reg;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_reg <= 1'b0;
            drive_reg <= 1'b0;
            off_reg <= `LORL_RST_TIME;
            hold_reg <= `LORL_RST_TIME;
        end else begin
            // Setting wins over a clearing in the same cycle
            if (restore)
                latch_reg <= restore_val;
            else if (latch_en && comb_st)
                latch_reg <= 1'b1;
            else if (clear_ok)
                latch_reg <= 1'b0;
            if (raw)
                off_reg <= off_t;
            else if (tick && off_reg != `LORL_RST_TIME)
                off_reg <= off_reg - `LORL_TIME_STEP;
            if (want != drive_reg && hold_reg == `LORL_RST_TIME) begin
                drive_reg <= want;
                hold_reg <= hold_t;
            end else if (tick && hold_reg != `LORL_RST_TIME) begin
                hold_reg <= hold_reg - `LORL_TIME_STEP;
            end
        end
    end
endmodule // lorl_chan
`default_nettype wire

//--- lorl_monitor.sv
// Port checker for the relay output block
`timescale 1ns/1ns
`default_nettype none
module lorl_monitor (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Latches and contacts
    input wire logic latch_restore,
    input wire logic [3:0] latch_restore_val,
    input wire logic [3:0] latch_save_val,
    input wire logic boot_done,
    input wire logic internal_fault,
    input wire logic health_contact,
    input wire logic [3:0] relay_drive
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic rd = psel && penable && !pwrite;
    health_up_a: assert property (boot_done && !internal_fault |=> health_contact)
        else $error("health contact stayed off");
    health_off_a: assert property (!boot_done || internal_fault |=> !health_contact)
        else $error("health contact on too early");
    restore_load_a: assert property (latch_restore |=> latch_save_val == $past(latch_restore_val))
        else $error("latch restore lost");
    reset_clear_a: assert property ($rose(presetn) |-> !relay_drive && !latch_save_val)
        else $error("outputs not clear after reset");
    ready_high_a: assert property (pready)
        else $error("slave not ready");
    bad_addr_a: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access accepted");
    idle_zero_a: assert property (!(psel && penable) |-> prdata == '0 && !pslverr)
        else $error("read data outside access");
    status_view_a: assert property (rd && paddr == 12'h008 |->
        prdata[7:0] == {latch_save_val, relay_drive} && prdata[12] == health_contact)
        else $error("status differs from outputs");
    cover property (latch_restore);
    cover property (rd && pslverr);
    cover property ($fell(health_contact));
endmodule // lorl_monitor
bind lorl_top lorl_monitor mon_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
    .pready, .pslverr, .latch_restore, .latch_restore_val, .latch_save_val, .boot_done,
    .internal_fault, .health_contact, .relay_drive);
`default_nettype wire

//--- lorl_regs.vh
// Constants of the latched output relay logic: map, fields, reset values, timing
`ifndef LORL_REGS_VH
`define LORL_REGS_VH

// Sizes
`define LORL_NCH 4
`define LORL_NTRIG 7
`define LORL_NSRC 32
`define LORL_IDX_W 5
`define LORL_SLOT_W 6
`define LORL_TIME_W 16

// Timing
`define LORL_CLK_NS 4
`define LORL_TICK_NS 1000000

// Byte addresses, channel page number and per-channel register selects
`define LORL_A_CTRL 12'h000
`define LORL_A_ACK 12'h004
`define LORL_A_STATUS 12'h008
`define LORL_CH_PAGE 6'h04
`define LORL_R_CFG 2'h0
`define LORL_R_ASG_LO 2'h1
`define LORL_R_ASG_HI 2'h2
`define LORL_R_TIME 2'h3

// Fields
`define LORL_CTRL_REMOTE 0
`define LORL_CFG_INV 6:0
`define LORL_CFG_CINV 7
`define LORL_CFG_MODE 8
`define LORL_CFG_LATCH 9
`define LORL_CFG_ACK_IDX 14:10
`define LORL_CFG_ACK_EN 15
`define LORL_ASG_LO_W 24
`define LORL_ASG_HI_W 18
`define LORL_TIME_HOLD 15:0
`define LORL_TIME_OFF 31:16
`define LORL_ST_DRIVE 3:0
`define LORL_ST_LATCH 7:4
`define LORL_ST_COMB 11:8
`define LORL_ST_HEALTH 12

// Reset values and timer decrement step
`define LORL_RST_WORD 32'h0000_0000
`define LORL_RST_NCH 4'h0
`define LORL_RST_TIME 16'h0000
`define LORL_TIME_STEP 16'h0001

`endif

//--- lorl_src_model.sv
// Model of the trigger and acknowledge sources
`timescale 1ns/1ns
`default_nettype none
module lorl_src_model (
    // Clock
    input wire logic pclk,
    // Bench requests
    input wire logic [31:0] want_src,
    input wire logic [2:0] want_ack,
    // Sources, levels synchronous to the clock
    output logic [31:0] trig_src,
    output logic local_clear_key,
    output logic scada_ack,
    output logic global_output_ack_signal
);
    // Registered so every level moves just after an edge, as real function outputs do
    always @(posedge pclk) begin
        trig_src <= want_src;
        {global_output_ack_signal, scada_ack, local_clear_key} <= want_ack;
    end
endmodule // lorl_src_model
`default_nettype wire

//--- lorl_top.v
// Relay output block: APB registers, trigger selection, tick, health contact
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "lorl_regs.vh"
module lorl_top #(
    parameter TICK_CYCLES = `LORL_TICK_NS / `LORL_CLK_NS
) (
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Trigger and acknowledge sources
    input wire [`LORL_NSRC-1:0] trig_src,
    input wire local_clear_key,
    input wire scada_ack,
    input wire global_output_ack_signal,
    // Latch retention
    input wire latch_restore,
    input wire [`LORL_NCH-1:0] latch_restore_val,
    output wire [`LORL_NCH-1:0] latch_save_val,
    // Health
    input wire boot_done,
    input wire internal_fault,
    output wire health_contact,
    // Relay drives
    output wire [`LORL_NCH-1:0] relay_drive
);
    reg [31:0] ctrl_reg;
    reg [31:0] cfg_reg [0:`LORL_NCH-1];
    reg [`LORL_ASG_LO_W-1:0] asg_lo_reg [0:`LORL_NCH-1];
    reg [`LORL_ASG_HI_W-1:0] asg_hi_reg [0:`LORL_NCH-1];
    reg [31:0] time_reg [0:`LORL_NCH-1];
    reg [`LORL_NCH-1:0] hmi_ack_reg;
    reg [`LORL_NCH-1:0] hmi_ack_next;
    reg health_reg;
    reg [31:0] tick_cnt_reg;
    reg tick_reg;
    wire [`LORL_NCH-1:0] comb_st;
    wire [`LORL_NCH-1:0] latch_q;
    wire remote_ok;
    wire all_ack;
    wire wr_en;
    wire rd_en;
    wire ch_hit;
    wire [1:0] ch_sel;
    wire [1:0] reg_sel;
    reg hit;
    integer i;

    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign ch_hit = (paddr[11:6] == `LORL_CH_PAGE);
    assign ch_sel = paddr[5:4];
    assign reg_sel = paddr[3:2];

    // Unmapped or misaligned addresses answer with an error
    always @* begin
        hit = 1'b0;
        if (paddr[1:0] != 2'h0)
            hit = 1'b0;
        else if (paddr == `LORL_A_CTRL)
            hit = 1'b1;
        else if (paddr == `LORL_A_ACK)
            hit = 1'b1;
        else if (paddr == `LORL_A_STATUS)
            hit = 1'b1;
        else if (ch_hit)
            hit = 1'b1;
    end
    assign pslverr = psel & penable & ~hit;

    // Read data
    always @* begin
        prdata = `LORL_RST_WORD;
        if (!rd_en || !hit) begin
            prdata = `LORL_RST_WORD;
        end else if (paddr == `LORL_A_CTRL) begin
            prdata = ctrl_reg;
        end else if (paddr == `LORL_A_STATUS) begin
            prdata[`LORL_ST_DRIVE] = relay_drive;
            prdata[`LORL_ST_LATCH] = latch_q;
            prdata[`LORL_ST_COMB] = comb_st;
            prdata[`LORL_ST_HEALTH] = health_reg;
        end else if (ch_hit && reg_sel == `LORL_R_CFG) begin
            prdata = cfg_reg[ch_sel];
        end else if (ch_hit && reg_sel == `LORL_R_ASG_LO) begin
            prdata[`LORL_ASG_LO_W-1:0] = asg_lo_reg[ch_sel];
        end else if (ch_hit && reg_sel == `LORL_R_ASG_HI) begin
            prdata[`LORL_ASG_HI_W-1:0] = asg_hi_reg[ch_sel];
        end else if (ch_hit && reg_sel == `LORL_R_TIME) begin
            prdata = time_reg[ch_sel];
        end
    end

    // Operator acknowledge from the panel lasts one cycle
    always @* begin
        hmi_ack_next = `LORL_RST_NCH;
        if (wr_en && paddr == `LORL_A_ACK)
            hmi_ack_next = pwdata[`LORL_NCH-1:0];
    end

    // Register writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `LORL_RST_WORD;
            hmi_ack_reg <= `LORL_RST_NCH;
            for (i = 0; i < `LORL_NCH; i = i + 1) begin
                cfg_reg[i] <= `LORL_RST_WORD;
                asg_lo_reg[i] <= {`LORL_ASG_LO_W{1'b0}};
                asg_hi_reg[i] <= {`LORL_ASG_HI_W{1'b0}};
                time_reg[i] <= `LORL_RST_WORD;
            end
        end else begin
            hmi_ack_reg <= hmi_ack_next;
            if (wr_en && paddr == `LORL_A_CTRL)
                ctrl_reg <= {31'h0000_0000, pwdata[`LORL_CTRL_REMOTE]};
            if (wr_en && ch_hit && paddr[1:0] == 2'h0) begin
                if (reg_sel == `LORL_R_CFG)
                    cfg_reg[ch_sel] <= {16'h0000, pwdata[15:0]};
                else if (reg_sel == `LORL_R_ASG_LO)
                    asg_lo_reg[ch_sel] <= pwdata[`LORL_ASG_LO_W-1:0];
                else if (reg_sel == `LORL_R_ASG_HI)
                    asg_hi_reg[ch_sel] <= pwdata[`LORL_ASG_HI_W-1:0];
                else
                    time_reg[ch_sel] <= pwdata;
            end
        end
    end

    // Common timebase; one pulse per tick period
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_reg <= `LORL_RST_WORD;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg >= TICK_CYCLES - 1) begin
            tick_cnt_reg <= `LORL_RST_WORD;
            tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
            tick_reg <= 1'b0;
        end
    end

    // Health contact is energised only when healthy, so a dead device opens it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            health_reg <= 1'b0;
        else
            health_reg <= boot_done & ~internal_fault;
    end
    assign health_contact = health_reg;

    // Collective acknowledges need remote reset permission
    assign remote_ok = ctrl_reg[`LORL_CTRL_REMOTE];
    assign all_ack = remote_ok & (global_output_ack_signal | scada_ack);

    assign latch_save_val = latch_q;

    genvar c;
    genvar k;
    generate
        for (c = 0; c < `LORL_NCH; c = c + 1) begin : g_ch
            wire [`LORL_SLOT_W*`LORL_NTRIG-1:0] asg;
            wire [`LORL_NTRIG-1:0] tsel;
            wire [`LORL_NTRIG-1:0] aen;
            wire [`LORL_IDX_W-1:0] ack_idx;
            wire ack_sig;
            wire ack_c;
            assign asg = {asg_hi_reg[c], asg_lo_reg[c]};
            for (k = 0; k < `LORL_NTRIG; k = k + 1) begin : g_slot
                wire [`LORL_IDX_W-1:0] idx;
                assign idx = asg[`LORL_SLOT_W*k +: `LORL_IDX_W];
                assign tsel[k] = trig_src[idx];
                assign aen[k] = asg[`LORL_SLOT_W*k + `LORL_IDX_W];
            end
            assign ack_idx = cfg_reg[c][`LORL_CFG_ACK_IDX];
            // The chosen ack signal is only meaningful while latching
            assign ack_sig = cfg_reg[c][`LORL_CFG_ACK_EN] &
                             cfg_reg[c][`LORL_CFG_LATCH] & trig_src[ack_idx];
            assign ack_c = ack_sig | local_clear_key | hmi_ack_reg[c] | all_ack;
            lorl_chan u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .tick(tick_reg),
                .trig(tsel),
                .asg_en(aen),
                .inv(cfg_reg[c][`LORL_CFG_INV]),
                .cinv(cfg_reg[c][`LORL_CFG_CINV]),
                .mode(cfg_reg[c][`LORL_CFG_MODE]),
                .latch_en(cfg_reg[c][`LORL_CFG_LATCH]),
                .ack(ack_c),
                .hold_t(time_reg[c][`LORL_TIME_HOLD]),
                .off_t(time_reg[c][`LORL_TIME_OFF]),
                .restore(latch_restore),
                .restore_val(latch_restore_val[c]),
                .comb_st(comb_st[c]),
                .latch_q(latch_q[c]),
                .drive(relay_drive[c])
            );
        end
    endgenerate
endmodule // lorl_top
`default_nettype wire

//--- lorl_top_tb.sv
// Self-checking bench for the relay output block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module lorl_top_tb;
    logic pclk, presetn, psel, penable, pwrite, latch_restore, boot_done, internal_fault;
    logic pready, pslverr, local_clear_key, scada_ack, global_output_ack_signal, health_contact;
    logic [11:0] paddr;
    logic [11:0] bad[4] = '{12'h00c, 12'h002, 12'h140, 12'h0fe};
    logic [31:0] pwdata, prdata, want_src, trig_src, r, lo = '0, hi = '0;
    logic [3:0] latch_restore_val, latch_save_val, relay_drive;
    logic [2:0] want_ack;
    logic [8:0] cfg;
    logic c0, c1;
    logic [32:0] e, ex, exp_q[$];
    int failures = 0, samples_checked = 0;
    lorl_top #(.TICK_CYCLES(4)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .trig_src, .local_clear_key, .scada_ack,
        .global_output_ack_signal, .latch_restore, .latch_restore_val, .latch_save_val,
        .boot_done, .internal_fault, .health_contact, .relay_drive);
    lorl_src_model src_u (.pclk, .want_src, .want_ack, .trig_src, .local_clear_key,
        .scada_ack, .global_output_ack_signal);
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Idle cycle at the end so a following call never reassigns psel in the same step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        cyc(1);
        penable <= 1'b1;
        do cyc(1); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] x);
        exp_q.push_back(x);
        apb(1'b0, a, '0);
    endtask
    function automatic logic [32:0] st(input logic [3:0] dv, lt, cb);
        return {20'h0_0000, 1'b1, cb, lt, dv};
    endfunction
    // Ack kinds: 0 channel source, 1 key, 2 SCADA, 3 global, 4 HMI register, 5 latch off
    task automatic pulse(input int k);
        case (k)
            0: want_src <= 32'h0010_0000;
            4: apb(1'b1, 12'h004, 32'h0000_0001);
            5: apb(1'b1, 12'h100, '0);
            default: want_ack[k - 1] <= 1'b1;
        endcase
        cyc(3);
        want_src <= '0;
        want_ack <= '0;
        cyc(3);
    endtask
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready) begin
            ex = exp_q.pop_front();
            `CHK({pslverr, prdata}, ex)
        end
    end
    task automatic wrap_up;
        if (failures == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        {psel, penable, pwrite, latch_restore, boot_done, internal_fault, presetn, paddr,
            pwdata, want_src, want_ack, latch_restore_val} = '0;
        r = $urandom(32'hd47142d2);
        cyc(20);
        presetn <= 1'b1;
        repeat (8) begin
            {boot_done, internal_fault} <= 2'($urandom);
            cyc(2);
        end
        boot_done <= 1'b1;
        internal_fault <= 1'b0;
        for (int k = 0; k < 4; k++) lo |= (k + 32) << (6 * k);
        for (int k = 0; k < 3; k++) hi |= (k + 36) << (6 * k);
        apb(1'b1, 12'h104, lo);
        apb(1'b1, 12'h108, hi);
        apb(1'b1, 12'h114, 32'h0000_0027);
        apb(1'b1, 12'h120, 32'h0000_0080);
        repeat (8) begin
            cfg = 9'($urandom);
            r = $urandom;
            apb(1'b1, 12'h100, {23'h0, cfg});
            apb(1'b1, 12'h110, {24'h0, cfg[7], 7'h7f});
            want_src <= r;
            cyc(3);
            c0 = |(r[6:0] ^ cfg[6:0]) ^ cfg[7];
            c1 = !r[7] ^ cfg[7];
            e = st({2'h0, c1, c0 ^ cfg[8]}, 4'h0, {2'h0, c1, c0});
            rd(12'h008, e);
        end
        foreach (bad[i]) rd(bad[i], {1'b1, 32'h0000_0000});
        want_src <= '0;
        apb(1'b1, 12'h110, '0);
        apb(1'b1, 12'h10c, 32'h0003_0000);
        for (int k = 0; k < 6; k++) begin
            apb(1'b1, 12'h100, 32'h0000_d200);
            want_src <= 32'h0000_0001;
            cyc(3);
            rd(12'h008, st(4'h1, 4'h1, 4'h1));
            want_src <= 32'h0010_0001;
            cyc(3);
            want_src <= '0;
            cyc(2);
            want_src <= 32'h0010_0000;
            cyc(2);
            want_src <= '0;
            rd(12'h008, st(4'h1, 4'h1, 4'h0));
            cyc(20);
            if (k == 2 || k == 3) begin
                pulse(k);
                rd(12'h008, st(4'h1, 4'h1, 4'h0));
                apb(1'b1, 12'h000, 32'h0000_0001);
            end
            pulse(k);
            rd(12'h008, st(4'h0, 4'h0, 4'h0));
            apb(1'b1, 12'h000, '0);
        end
        apb(1'b1, 12'h134, 32'h0000_0029);
        apb(1'b1, 12'h13c, 32'h0000_0004);
        want_src <= 32'h0000_0200;
        cyc(2);
        want_src <= '0;
        cyc(3);
        rd(12'h008, st(4'h8, 4'h0, 4'h0));
        cyc(20);
        rd(12'h008, st(4'h0, 4'h0, 4'h0));
        apb(1'b1, 12'h100, 32'h0000_0200);
        r = $urandom;
        latch_restore_val <= r[3:0];
        latch_restore <= 1'b1;
        cyc(1);
        latch_restore <= 1'b0;
        cyc(3);
        rd(12'h008, st({3'h0, r[0]}, {3'h0, r[0]}, 4'h0));
        wrap_up;
    end
    initial begin
        cyc(20000);
        failures++;
        wrap_up;
    end
endmodule // lorl_top_tb
`default_nettype wire
